// ==== hdl/cfg_link_if.sv ====
`timescale 1ns/1ps
interface cfg_link_if;
    logic ready_dev_oe_n;
    logic init_ld_oe_n;
    logic ready_line;
    logic [cfg_pkg::addr_width-1:0] addr;
    logic [cfg_pkg::data_width-1:0] data;
    logic data_valid;
    logic data_ready;
    // wired-and: open drain low when enable low
    assign ready_line = ready_dev_oe_n & init_ld_oe_n;
    modport flash_end (
        output ready_dev_oe_n,
        input ready_line,
        input addr,
        output data,
        output data_valid,
        input data_ready
    );
    modport loader_end (
        output init_ld_oe_n,
        input ready_line,
        output addr,
        input data,
        input data_valid,
        output data_ready
    );
endinterface

// ==== hdl/cfg_pkg.sv ====
package cfg_pkg;
    localparam int addr_width = 23;
    localparam int data_width = 16;
    localparam int fifo_depth = 8;
    localparam int clk_period_ns = 100;
    // internal ready time after reset, in ns
    localparam int ready_time_ns = 1000;
    localparam int ready_cycles = (ready_time_ns + clk_period_ns - 1) / clk_period_ns;
    // program/erase operation length, in ns
    localparam int prog_time_ns = 2000;
    localparam int prog_cycles = prog_time_ns / clk_period_ns;
    localparam logic [addr_width-1:0] start_addr_reset = 23'h000000;
    typedef enum logic [1:0] {
        dev_reset = 2'h0,
        dev_wait_line = 2'h1,
        dev_burst = 2'h3
    } dev_state_type;
    typedef enum logic [1:0] {
        ld_idle = 2'h0,
        ld_load = 2'h1,
        ld_done = 2'h3
    } ld_state_type;
endpackage

// ==== hdl/flash_end.sv ====
`timescale 1ns/1ps
module flash_end #(
    parameter int ready_count = cfg_pkg::ready_cycles,
    parameter int prog_count = cfg_pkg::prog_cycles
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    cfg_link_if.flash_end link,
    input wire logic prog_enable_i,
    input wire logic prog_start_i,
    output logic prog_busy_o,
    output logic prog_refused_o,
    output logic [cfg_pkg::addr_width-1:0] mem_addr_o,
    input wire logic [cfg_pkg::data_width-1:0] mem_data_i
);
    cfg_pkg::dev_state_type state, next_state;
    logic [15:0] cnt, next_cnt;
    logic [cfg_pkg::addr_width-1:0] next_mem_addr;
    logic [1:0] line_sync, en_sync;
    logic ready_oe_n, next_ready_oe_n;
    logic [15:0] pcnt, next_pcnt;
    logic next_busy, next_refused;
    logic fifo_in_ready, fifo_in_valid, fifo_flush;
    word_fifo #(.width(cfg_pkg::data_width), .depth(cfg_pkg::fifo_depth)) buffer (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .flush_i(fifo_flush),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(mem_data_i),
        .out_valid_o(link.data_valid),
        .out_ready_i(link.data_ready),
        .out_data_o(link.data)
    );
    assign link.ready_dev_oe_n = ready_oe_n;
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            line_sync <= 2'h0;
            en_sync <= 2'h0;
        end else begin
            line_sync <= {line_sync[0], link.ready_line};
            en_sync <= {en_sync[0], prog_enable_i};
        end
    end
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_mem_addr = mem_addr_o;
        next_ready_oe_n = ready_oe_n;
        fifo_flush = 1'b0;
        fifo_in_valid = 1'b0;
        unique case (state)
            cfg_pkg::dev_reset: begin
                next_ready_oe_n = 1'b0;
                if (cnt == 16'(ready_count - 1)) begin
                    next_ready_oe_n = 1'b1;
                    next_state = cfg_pkg::dev_wait_line;
                end else begin
                    next_cnt = cnt + 16'h0001;
                end
            end
            cfg_pkg::dev_wait_line: begin
                fifo_flush = 1'b1;
                if (line_sync[1]) begin
                    next_mem_addr = link.addr;
                    next_state = cfg_pkg::dev_burst;
                end
            end
            cfg_pkg::dev_burst: begin
                fifo_in_valid = 1'b1;
                if (fifo_in_ready) begin
                    next_mem_addr = mem_addr_o + 23'h000001;
                end
                if (!line_sync[1]) begin
                    fifo_flush = 1'b1;
                    fifo_in_valid = 1'b0;
                    next_mem_addr = mem_addr_o;
                    next_state = cfg_pkg::dev_wait_line;
                end
            end
            default: next_state = cfg_pkg::dev_reset;
        endcase
    end
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= cfg_pkg::dev_reset;
            cnt <= 16'h0000;
            mem_addr_o <= cfg_pkg::start_addr_reset;
            ready_oe_n <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            mem_addr_o <= next_mem_addr;
            ready_oe_n <= next_ready_oe_n;
        end
    end
    // program/erase: supply level checked once at start only
    always_comb begin
        next_pcnt = pcnt;
        next_busy = prog_busy_o;
        next_refused = prog_refused_o;
        if (prog_busy_o) begin
            if (pcnt == 16'h0000) begin
                next_busy = 1'b0;
            end else begin
                next_pcnt = pcnt - 16'h0001;
            end
        end else if (prog_start_i) begin
            next_busy = en_sync[1];
            next_refused = !en_sync[1];
            next_pcnt = 16'(prog_count - 1);
        end
    end
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pcnt <= 16'h0000;
            prog_busy_o <= 1'b0;
            prog_refused_o <= 1'b0;
        end else begin
            pcnt <= next_pcnt;
            prog_busy_o <= next_busy;
            prog_refused_o <= next_refused;
        end
    end
endmodule

// ==== hdl/loader_end.sv ====
`timescale 1ns/1ps
module loader_end #(
    parameter int word_count = 16
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    cfg_link_if.loader_end link,
    input wire logic start_i,
    input wire logic [cfg_pkg::addr_width-1:0] start_addr_i,
    output logic [cfg_pkg::data_width-1:0] word_o,
    output logic word_valid_o,
    output logic done_o
);
    cfg_pkg::ld_state_type state, next_state;
    logic init_oe_n, next_init_oe_n;
    logic [31:0] cnt, next_cnt;
    logic [cfg_pkg::addr_width-1:0] addr, next_addr;
    logic [cfg_pkg::data_width-1:0] next_word;
    logic next_valid, next_done;
    logic [1:0] line_sync;
    assign link.init_ld_oe_n = init_oe_n;
    // static start address; flash counts upward itself
    assign link.addr = addr;
    assign link.data_ready = state == cfg_pkg::ld_load;
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            line_sync <= 2'h0;
        end else begin
            line_sync <= {line_sync[0], link.ready_line};
        end
    end
    always_comb begin
        next_state = state;
        next_init_oe_n = init_oe_n;
        next_cnt = cnt;
        next_addr = addr;
        next_word = word_o;
        next_valid = 1'b0;
        next_done = done_o;
        unique case (state)
            cfg_pkg::ld_idle: begin
                if (start_i) begin
                    next_init_oe_n = 1'b1;
                    next_addr = start_addr_i;
                end
                if (init_oe_n && line_sync[1]) begin
                    next_state = cfg_pkg::ld_load;
                    next_cnt = 32'h00000000;
                end
            end
            cfg_pkg::ld_load: begin
                if (link.data_valid) begin
                    next_word = link.data;
                    next_valid = 1'b1;
                    next_cnt = cnt + 32'h00000001;
                    if (cnt == 32'(word_count - 1)) begin
                        next_state = cfg_pkg::ld_done;
                        next_done = 1'b1;
                    end
                end
            end
            cfg_pkg::ld_done: begin
                if (start_i) begin
                    next_done = 1'b0;
                    next_init_oe_n = 1'b0;
                    next_addr = start_addr_i;
                    next_state = cfg_pkg::ld_idle;
                end
            end
            default: next_state = cfg_pkg::ld_idle;
        endcase
    end
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= cfg_pkg::ld_idle;
            init_oe_n <= 1'b0;
            cnt <= 32'h00000000;
            addr <= cfg_pkg::start_addr_reset;
            word_o <= 16'h0000;
            word_valid_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            state <= next_state;
            init_oe_n <= next_init_oe_n;
            cnt <= next_cnt;
            addr <= next_addr;
            word_o <= next_word;
            word_valid_o <= next_valid;
            done_o <= next_done;
        end
    end
endmodule

// ==== hdl/word_fifo.sv ====
`timescale 1ns/1ps
module word_fifo #(
    parameter int width = 16,
    parameter int depth = 8
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [width-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [width-1:0] out_data_o
);
    localparam int aw = $clog2(depth);
    logic [width-1:0] mem [depth];
    logic [aw:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic push, pop;
    always_comb begin
        in_ready_o = (wr_ptr - rd_ptr) != (aw+1)'(depth);
        out_valid_o = wr_ptr != rd_ptr;
        out_data_o = mem[rd_ptr[aw-1:0]];
        push = in_valid_i & in_ready_o;
        pop = out_valid_o & out_ready_i;
        next_wr_ptr = flush_i ? '0 : wr_ptr + (aw+1)'(push);
        next_rd_ptr = flush_i ? '0 : rd_ptr + (aw+1)'(pop);
    end
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end
    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem[wr_ptr[aw-1:0]] <= in_data_i;
        end
    end
endmodule

// ==== tb/link_chk.sv ====
`timescale 1ns/1ps
// words on the link are assumed to carry the low half of their array address
module link_chk (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ready_dev_oe_n,
    input wire logic init_ld_oe_n,
    input wire logic ready_line,
    input wire logic [cfg_pkg::addr_width-1:0] addr,
    input wire logic [cfg_pkg::data_width-1:0] data,
    input wire logic data_valid,
    input wire logic data_ready
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    a_line_wired_and: assert property (ready_line == (ready_dev_oe_n & init_ld_oe_n))
        else $error("ready line not wired-and");
    a_dev_hold_low: assert property ($fell(rst_i) |-> !ready_dev_oe_n [*8])
        else $error("flash released ready too early");
    a_dev_release_bound: assert property ($fell(rst_i) |-> ##[8:20] ready_dev_oe_n)
        else $error("flash never released ready");
    a_sync_before_data: assert property ($rose(data_valid) |-> $past(ready_line) && $past(ready_line, 2))
        else $error("data before both released");
    a_first_word_addr: assert property ($rose(data_valid) |-> data == addr[15:0])
        else $error("first word not at start address");
    a_word_ascend: assert property (data_valid && data_ready ##1 data_valid && data_ready |->
        data == $past(data) + 16'h0001) else $error("words not ascending");
    a_ready_needs_line: assert property (data_ready |-> ready_line)
        else $error("loader accepts with line low");
    a_restart_flush: assert property ($fell(ready_line) |-> ##[1:6] !data_valid)
        else $error("burst not stopped by line low");
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    localparam int wc = 12;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic prog_en = 1'b1;
    logic prog_go = 1'b0;
    logic ld_go = 1'b0;
    logic [cfg_pkg::addr_width-1:0] ld_addr = 23'h000000;
    logic [cfg_pkg::addr_width-1:0] mem_addr;
    logic prog_busy, prog_refused, word_valid, ld_done;
    logic [15:0] word;
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    always #50 mclk_i = ~mclk_i;
    cfg_link_if link();
    // array word equals the low half of its address, so expectations follow from addresses
    flash_end #(.ready_count(10), .prog_count(20)) u_flash_end (.mclk_i(mclk_i), .rst_i(rst_i), .link(link),
        .prog_enable_i(prog_en), .prog_start_i(prog_go), .prog_busy_o(prog_busy),
        .prog_refused_o(prog_refused), .mem_addr_o(mem_addr), .mem_data_i(mem_addr[15:0]));
    loader_end #(.word_count(wc)) u_loader_end (.mclk_i(mclk_i), .rst_i(rst_i), .link(link),
        .start_i(ld_go), .start_addr_i(ld_addr), .word_o(word), .word_valid_o(word_valid), .done_o(ld_done));
    link_chk u_link_chk (.mclk_i(mclk_i), .rst_i(rst_i), .ready_dev_oe_n(link.ready_dev_oe_n),
        .init_ld_oe_n(link.init_ld_oe_n), .ready_line(link.ready_line), .addr(link.addr),
        .data(link.data), .data_valid(link.data_valid), .data_ready(link.data_ready));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    task automatic pulse_ld();
        ld_go = 1'b1;
        tick(1);
        ld_go = 1'b0;
    endtask
    task automatic prog(input logic en);
        prog_en = en;
        tick(3);
        prog_go = 1'b1;
        tick(1);
        prog_go = 1'b0;
        tick(3);
    endtask
    task automatic load(input logic [cfg_pkg::addr_width-1:0] a);
        int k;
        k = 0;
        ld_addr = a;
        pulse_ld();
        for (int i = 0; i < wc; i++) begin
            while (word_valid !== 1'b1 && k < 200) begin
                tick(1);
                k++;
            end
            check(word, 16'(a + i));
            tick(1);
        end
        tick(2);
        check(ld_done, 1'b1);
        // loader stopped taking, so the buffer fills and the array address stalls
        tick(6);
        check(link.data_valid, 1'b1);
        check(link.data, 16'(a + wc));
        check(mem_addr, 23'(a + wc + cfg_pkg::fifo_depth));
    endtask
    initial begin
        tick(16);
        rst_i = 1'b0;
        check(link.ready_line, 1'b0);
        // loader starts while the flash still holds off
        load(23'h000010);
        pulse_ld();
        tick(3);
        check(link.ready_line, 1'b0);
        check(link.data_valid, 1'b0);
        // restarted burst crosses the 16-bit word wrap
        load(23'h00FFFA);
        prog(1'b0);
        check({prog_busy, prog_refused}, 2'b01);
        prog(1'b1);
        check({prog_busy, prog_refused}, 2'b10);
        prog_en = 1'b0;
        tick(10);
        check(prog_busy, 1'b1);
        tick(12);
        check({prog_busy, prog_refused}, 2'b00);
        tally_and_finish();
    end
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            tally_and_finish();
        end
    end
endmodule
